//--- core/pcsc_ctrl.sv
`timescale 1ns/1ps
module pcsc_ctrl (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Link pins
    input  wire logic        ref_clk_in_i,
    input  wire logic        ext_fb_in_i,
    // Configuration
    input  wire logic [1:0]  fb_route_i,
    input  wire logic        ref_passthru_i,
    input  wire logic [3:0]  ref_divider_i,
    input  wire logic [5:0]  fb_divider_i,
    input  wire logic [2:0]  vco_out_divider_i,
    input  wire logic        fb_delay_dyn_i,
    input  wire logic        out_delay_dyn_i,
    input  wire logic [3:0]  fb_delay_fixed_i,
    input  wire logic [3:0]  out_delay_fixed_i,
    input  wire logic [7:0]  fine_delay_sel_i,
    input  wire logic        shifter_ratio_sel_i,
    input  wire logic        quad_shift_i,
    input  wire logic        hold_ctrl_en_i,
    input  wire logic        low_power_hold_i,
    // Clock outputs
    output logic             synth_clk_global_o,
    output logic             synth_clk_fabric_o,
    output logic             synth_clk_global_port_a_o,
    output logic             synth_clk_fabric_port_a_o,
    // Status
    output logic             lock_o,
    output logic             low_power_o,
    output logic [3:0]       fb_delay_taps_o,
    output logic [3:0]       out_delay_taps_o,
    output logic [11:0]      fb_delay_ps_o,
    output logic [11:0]      out_delay_ps_o,
    output logic [2:0]       shifter_div_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] ref_sync_q, ref_sync_d, ext_sync_q, ext_sync_d;
    logic       ref_lvl_q, ref_lvl_d, ext_lvl_q, ext_lvl_d;
    logic       ref_rise, ext_rise;

    always_comb begin
        ref_sync_d = {ref_sync_q[1:0], ref_clk_in_i};
        ext_sync_d = {ext_sync_q[1:0], ext_fb_in_i};
        // Glitch filter: a change counts once stages two and three agree
        ref_lvl_d  = (ref_sync_q[1] == ref_sync_q[2]) ? ref_sync_q[2]
                                                       : ref_lvl_q;
        ext_lvl_d  = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2]
                                                       : ext_lvl_q;
        ref_rise   = ref_lvl_d & ~ref_lvl_q;
        ext_rise   = ext_lvl_d & ~ext_lvl_q;
    end

    // ------------------------------------------------------------
    // Reference period and frame
    // ------------------------------------------------------------
    logic [15:0] per_cnt_q, per_cnt_d, per_q, per_d;
    logic        stable_q, stable_d;
    logic [3:0]  frame_q, frame_d;
    logic        frame_start;
    logic [15:0] per_diff;

    always_comb begin
        per_diff  = (per_cnt_q > per_q) ? per_cnt_q - per_q
                                        : per_q - per_cnt_q;
        per_cnt_d = (per_cnt_q == pcsc_pkg::PER_MAX) ? per_cnt_q
                                                     : per_cnt_q + 16'h0001;
        per_d     = per_q;
        stable_d  = stable_q;
        frame_d   = frame_q;
        if (ref_rise) begin
            per_cnt_d = 16'h0001;
            per_d     = per_cnt_q;
            stable_d  = (per_diff <= 16'h0001)
                        && (per_cnt_q != pcsc_pkg::PER_MAX);
            frame_d   = (frame_q >= ref_divider_i) ? 4'h0 : frame_q + 4'h1;
        end else if (per_cnt_q == pcsc_pkg::PER_MAX) begin
            // A stalled reference can never be tracked
            stable_d = 1'b0;
        end
        frame_start = ref_rise && (frame_q == 4'h0);
    end

    // ------------------------------------------------------------
    // Half-period computation
    // ------------------------------------------------------------
    logic [23:0] div_num, div_quo;
    logic [15:0] div_den;
    logic [6:0]  fb_p1;
    logic [2:0]  den_shift;
    logic        div_done;
    logic [15:0] half_q, half_d;
    logic        half_ok_q, half_ok_d;

    always_comb begin
        fb_p1     = {1'b0, fb_divider_i} + 7'h01;
        // Simple route adds the output divider of the oscillator
        den_shift = (fb_route_i == pcsc_pkg::ROUTE_SIMPLE)
                    ? vco_out_divider_i : 3'h0;
        div_num   = 24'(per_q) * 24'({1'b0, ref_divider_i} + 5'h01);
        div_den   = 16'({fb_p1, 1'b0}) << den_shift;
        half_d    = half_q;
        half_ok_d = half_ok_q;
        if (div_done) begin
            half_ok_d = 1'b1;
            if (div_quo == 24'h000000) begin
                half_d = pcsc_pkg::HALF_RST;
            end else if (div_quo[23:16] != 8'h00) begin
                half_d = 16'hffff;
            end else begin
                half_d = div_quo[15:0];
            end
        end
    end

    pcsc_divider u_div (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .start_i (frame_start & stable_q),
        .num_i   (div_num),
        .den_i   (div_den),
        .done_o  (div_done),
        .quo_o   (div_quo)
    );

    // ------------------------------------------------------------
    // Synthesized clock and output mux
    // ------------------------------------------------------------
    logic        synth_q, synth_d, out_d;
    logic [15:0] oc_q, oc_d;
    logic        hold_act, quad_act, synth_rise;
    logic        glb_q, fab_q, glb_a_q, fab_a_q;

    always_comb begin
        hold_act = low_power_hold_i & hold_ctrl_en_i;
        // Quarter shift needs the divide-by-4 shifter
        quad_act = quad_shift_i & ~shifter_ratio_sel_i
                   & (fb_route_i == pcsc_pkg::ROUTE_PHASE_DELAY);
        synth_d  = synth_q;
        oc_d     = oc_q;
        if (hold_act) begin
            synth_d = synth_q;
        end else if (frame_start && half_ok_q) begin
            // Realign, optionally a quarter period late
            if (quad_act) begin
                synth_d = 1'b0;
                oc_d    = half_q - (half_q >> 1);
            end else begin
                synth_d = 1'b1;
                oc_d    = 16'h0000;
            end
        end else if (half_ok_q) begin
            if (oc_q + 16'h0001 >= half_q) begin
                synth_d = ~synth_q;
                oc_d    = 16'h0000;
            end else begin
                oc_d = oc_q + 16'h0001;
            end
        end
        synth_rise = synth_d & ~synth_q;
        // Reference passthrough on the simple route
        if (hold_act) begin
            out_d = glb_q;
        end else if (fb_route_i == pcsc_pkg::ROUTE_SIMPLE
                     && ref_passthru_i) begin
            out_d = ref_lvl_q;
        end else begin
            out_d = synth_q;
        end
    end

    // ------------------------------------------------------------
    // Feedback and lock
    // ------------------------------------------------------------
    pcsc_pkg::pcsc_lock_t lk_q, lk_d;
    logic [2:0] lk_cnt_q, lk_cnt_d;
    logic       fb_seen_q, fb_seen_d, fb_edge, lock_d;

    always_comb begin
        fb_edge   = (fb_route_i == pcsc_pkg::ROUTE_EXTERNAL) ? ext_rise
                                                             : synth_rise;
        // An edge in the clearing cycle is kept
        fb_seen_d = fb_edge ? 1'b1 : (frame_start ? 1'b0 : fb_seen_q);
        lk_d      = lk_q;
        lk_cnt_d  = lk_cnt_q;
        // Lock only after several aligned frames
        case (lk_q)
            pcsc_pkg::LK_IDLE: begin
                lk_cnt_d = 3'h0;
                if (frame_start && stable_q) begin
                    lk_d = pcsc_pkg::LK_ACQUIRE;
                end
            end
            pcsc_pkg::LK_ACQUIRE: begin
                if (!stable_q) begin
                    lk_d = pcsc_pkg::LK_IDLE;
                end else if (frame_start) begin
                    if (fb_seen_q && half_ok_q) begin
                        lk_cnt_d = lk_cnt_q + 3'h1;
                        if (lk_cnt_q + 3'h1 == pcsc_pkg::LOCK_FRAMES) begin
                            lk_d = pcsc_pkg::LK_LOCKED;
                        end
                    end else begin
                        lk_d = pcsc_pkg::LK_IDLE;
                    end
                end
            end
            pcsc_pkg::LK_LOCKED: begin
                if (!stable_q || (frame_start && !fb_seen_q)) begin
                    lk_d = pcsc_pkg::LK_IDLE;
                end
            end
            default: begin
                lk_d = pcsc_pkg::LK_IDLE;
            end
        endcase
        lock_d = (lk_d == pcsc_pkg::LK_LOCKED);
    end

    // ------------------------------------------------------------
    // Delay taps and shifter
    // ------------------------------------------------------------
    logic [3:0]  fb_taps_d, out_taps_d;
    logic [11:0] fb_ps_d, out_ps_d;
    logic [2:0]  shdiv_d;

    always_comb begin
        // Feedback taps, dynamic only when selected
        fb_taps_d  = fb_delay_dyn_i ? fine_delay_sel_i[3:0] : fb_delay_fixed_i;
        // Output-port taps from the upper select bits
        out_taps_d = out_delay_dyn_i ? fine_delay_sel_i[7:4]
                                     : out_delay_fixed_i;
        // 150 ps per tap, 16 taps
        fb_ps_d    = 12'({8'h00, fb_taps_d} + 12'h001) * pcsc_pkg::TAP_PS;
        out_ps_d   = 12'({8'h00, out_taps_d} + 12'h001) * pcsc_pkg::TAP_PS;
        shdiv_d    = shifter_ratio_sel_i ? pcsc_pkg::SHIFT_DIV7
                                         : pcsc_pkg::SHIFT_DIV4;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Active-low reset clears lock and restarts acquisition
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_sync_q <= 3'h0;
            ext_sync_q <= 3'h0;
            ref_lvl_q  <= 1'b0;
            ext_lvl_q  <= 1'b0;
            per_cnt_q  <= 16'h0000;
            per_q      <= 16'h0000;
            stable_q   <= 1'b0;
            frame_q    <= 4'h0;
            half_q     <= pcsc_pkg::HALF_RST;
            half_ok_q  <= 1'b0;
            synth_q    <= 1'b0;
            oc_q       <= 16'h0000;
            glb_q      <= 1'b0;
            fab_q      <= 1'b0;
            glb_a_q    <= 1'b0;
            fab_a_q    <= 1'b0;
            lk_q       <= pcsc_pkg::LK_IDLE;
            lk_cnt_q   <= 3'h0;
            fb_seen_q  <= 1'b0;
            lock_o     <= 1'b0;
            low_power_o      <= 1'b0;
            fb_delay_taps_o  <= pcsc_pkg::TAPS_RST;
            out_delay_taps_o <= pcsc_pkg::TAPS_RST;
            fb_delay_ps_o    <= pcsc_pkg::TAP_PS;
            out_delay_ps_o   <= pcsc_pkg::TAP_PS;
            shifter_div_o    <= pcsc_pkg::SHIFT_DIV4;
        end else begin
            ref_sync_q <= ref_sync_d;
            ext_sync_q <= ext_sync_d;
            ref_lvl_q  <= ref_lvl_d;
            ext_lvl_q  <= ext_lvl_d;
            per_cnt_q  <= per_cnt_d;
            per_q      <= per_d;
            stable_q   <= stable_d;
            frame_q    <= frame_d;
            half_q     <= half_d;
            half_ok_q  <= half_ok_d;
            synth_q    <= synth_d;
            oc_q       <= oc_d;
            glb_q      <= out_d;
            fab_q      <= out_d;
            glb_a_q    <= out_d;
            fab_a_q    <= out_d;
            lk_q       <= lk_d;
            lk_cnt_q   <= lk_cnt_d;
            fb_seen_q  <= fb_seen_d;
            lock_o     <= lock_d;
            low_power_o      <= hold_act;
            fb_delay_taps_o  <= fb_taps_d;
            out_delay_taps_o <= out_taps_d;
            fb_delay_ps_o    <= fb_ps_d;
            out_delay_ps_o   <= out_ps_d;
            shifter_div_o    <= shdiv_d;
        end
    end

    assign synth_clk_global_o        = glb_q;
    assign synth_clk_fabric_o        = fab_q;
    assign synth_clk_global_port_a_o = glb_a_q;
    assign synth_clk_fabric_port_a_o = fab_a_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_held;
        low_power_hold_i && hold_ctrl_en_i;
    endsequence

    sequence s_passthru;
        !(low_power_hold_i && hold_ctrl_en_i) && ref_passthru_i
        && (fb_route_i == 2'b00);
    endsequence

    a_bypass_ref: assert property (s_passthru |=>
        synth_clk_global_o == $past(ref_lvl_q))
        else $error("passthrough output does not follow reference");
    a_ext_fb_only: assert property ((fb_route_i == 2'b11) && !ext_rise
        && !frame_start && !fb_seen_q |=> !fb_seen_q)
        else $error("feedback seen without external edge");
    a_fb_taps_sel: assert property (nrst_i && !fb_delay_dyn_i |=>
        fb_delay_taps_o == $past(fb_delay_fixed_i))
        else $error("fixed feedback taps ignored");
    a_fb_delay_ps: assert property (1'b1 |->
        fb_delay_ps_o == 12'(({8'h00, fb_delay_taps_o} + 12'h001) * 12'h096))
        else $error("feedback delay not (n+1) taps");
    a_out_taps_dyn: assert property (nrst_i && out_delay_dyn_i |=>
        out_delay_taps_o == $past(fine_delay_sel_i[7:4]))
        else $error("dynamic output taps not taken");
    a_hold_freeze: assert property (nrst_i ##0 s_held ##1 s_held |->
        $stable(synth_clk_global_o) && low_power_o)
        else $error("output moved while held");
    a_nets_equal: assert property (1'b1 |->
        synth_clk_global_o == synth_clk_fabric_o
        && synth_clk_global_port_a_o == synth_clk_fabric_port_a_o)
        else $error("global and fabric outputs differ");
    a_lock_cause: assert property ($rose(lock_o) |->
        $past(stable_q) && $past(half_ok_q) && $past(fb_seen_q))
        else $error("lock rose without alignment");
    a_shift_ratio: assert property (nrst_i |=>
        shifter_div_o == ($past(shifter_ratio_sel_i) ? 3'h7 : 3'h4))
        else $error("shifter ratio wrong");
    a_stall_unlock: assert property ((per_cnt_q == 16'hffff) |->
        ##[1:2] !lock_o)
        else $error("lock held on stalled reference");

endmodule

//--- core/pcsc_pkg.sv
// Overview of operation
// - Simple route: passthrough low selects synthesized clock, high selects raw reference.
// - External feedback input drives the phase loop only on the external route.
// - Four feedback routes: oscillator, delay, shifter plus delay, external pin.
// - Dynamic fine-delay selects act only when that block is in dynamic mode.
// - Feedback delay block reports (n+1) taps of 150 ps on fb_delay_ps_o; neither output is shifted.
// - Output-port delay reports (n+1) x 150 ps for port A, dynamic from bits 7:4; port A carries the undelayed clock.
// - Hold input with hold enable set freezes the clock output at its level.
// - Global and fabric outputs carry the same synthesized clock.
// - Lock goes high only while output is aligned to the reference.
// - Shifter ratio 0 divides by 4, ratio 1 divides by 7.
// - Optional fixed quadrant shift of zero or ninety degrees, only on the shifter plus delay route with ratio 0.
// - Fine delay spans up to 2.4 ns in 150 ps steps.
// - Output duty cycle is corrected to about fifty percent.
// - Output frequency is reference times (fb divider+1) over (ref divider+1); the simple route also multiplies by 2^(oscillator output divider).
package pcsc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PER_W = 16;
    localparam int NUM_W = 24;
    localparam int DEN_W = 16;
    localparam int CNT_W = 5;
    localparam int PS_W  = 12;

    // ------------------------------------------------------------
    // Timing and constants
    // ------------------------------------------------------------
    localparam logic [PS_W-1:0]  TAP_PS      = 12'h096;
    localparam logic [4:0]       TAP_NUM     = 5'h10;
    localparam logic [PER_W-1:0] PER_MAX     = 16'hffff;
    localparam logic [2:0]       LOCK_FRAMES = 3'h4;
    localparam logic [2:0]       SHIFT_DIV4  = 3'h4;
    localparam logic [2:0]       SHIFT_DIV7  = 3'h7;
    localparam logic [CNT_W-1:0] DIV_STEPS   = 5'h18;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PER_W-1:0] HALF_RST = 16'h0001;
    localparam logic [3:0]       TAPS_RST = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ROUTE_SIMPLE      = 2'b00,
        ROUTE_DELAY       = 2'b01,
        ROUTE_PHASE_DELAY = 2'b10,
        ROUTE_EXTERNAL    = 2'b11
    } pcsc_route_t;

    typedef enum logic [1:0] {
        LK_IDLE    = 2'b00,
        LK_ACQUIRE = 2'b01,
        LK_LOCKED  = 2'b10
    } pcsc_lock_t;

endpackage

//--- core/pcsc_divider.sv
`timescale 1ns/1ps
module pcsc_divider (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       nrst_i,
    // Request
    input  wire logic                       start_i,
    input  wire logic [pcsc_pkg::NUM_W-1:0] num_i,
    input  wire logic [pcsc_pkg::DEN_W-1:0] den_i,
    // Answer
    output logic                            done_o,
    output logic      [pcsc_pkg::NUM_W-1:0] quo_o
);

    // ------------------------------------------------------------
    // Restoring divider, one quotient bit per cycle
    // ------------------------------------------------------------
    logic [pcsc_pkg::NUM_W-1:0] quo_q, quo_d;
    logic [pcsc_pkg::DEN_W:0]   rem_q, rem_d;
    logic [pcsc_pkg::DEN_W-1:0] den_q, den_d;
    logic [pcsc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic                       busy_q, busy_d;
    logic                       done_q, done_d;
    logic [pcsc_pkg::DEN_W:0]   trial;

    always_comb begin
        quo_d  = quo_q;
        rem_d  = rem_q;
        den_d  = den_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        trial  = {rem_q[pcsc_pkg::DEN_W-1:0], quo_q[pcsc_pkg::NUM_W-1]};
        // A new start restarts the division; the caller can start again before done
        if (start_i) begin
            quo_d  = num_i;
            rem_d  = '0;
            den_d  = (den_i == '0) ? 16'h0001 : den_i;
            cnt_d  = '0;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (trial >= {1'b0, den_q}) begin
                rem_d = trial - {1'b0, den_q};
                quo_d = {quo_q[pcsc_pkg::NUM_W-2:0], 1'b1};
            end else begin
                rem_d = trial;
                quo_d = {quo_q[pcsc_pkg::NUM_W-2:0], 1'b0};
            end
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == pcsc_pkg::DIV_STEPS - 5'h01) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            quo_q  <= '0;
            rem_q  <= '0;
            den_q  <= 16'h0001;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            quo_q  <= quo_d;
            rem_q  <= rem_d;
            den_q  <= den_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
    assign quo_o  = quo_q;

endmodule

//--- verification/pcsc_ref_model.sv
`timescale 1ns/1ps
module pcsc_ref_model (
    // Clock
    input  wire logic clk_i,
    // Control
    input  wire logic run_i,
    input  wire logic loop_i,
    input  wire logic fb_clk_i,
    // Pins
    output logic      ref_clk_o,
    output logic      ext_fb_o
);
    // ----
    // Source
    // ----
    logic [7:0] cnt_q = 8'h00;
    // Source runs on: period is 100 cycles, held low while stopped
    always @(posedge clk_i) begin
        cnt_q <= (!run_i || cnt_q == 8'h63) ? 8'h00 : cnt_q + 8'h01;
        ref_clk_o <= run_i && (cnt_q < 8'h32);
    end
    // Loopback path: pin is pulled low when not looped
    assign ext_fb_o = loop_i ? fb_clk_i : 1'b0;
endmodule

//--- verification/pcsc_ctrl_tb.sv
`timescale 1ns/1ps
module pcsc_ctrl_tb;
    logic        clk_i, nrst_i, run, loop, ref_clk, ext_fb;
    logic        pass, ratio, fb_dyn, out_dyn, hold_en, hold, quad;
    logic [1:0]  route;
    logic [3:0]  fb_fix, out_fix, fbt, outt;
    logic [7:0]  sel;
    logic        g, f, ga, fa, lock, lp;
    logic [11:0] fbps, outps;
    logic [2:0]  sdiv;
    int          error_cnt, comparisons, n, d, base;

    pcsc_ref_model src (.clk_i(clk_i), .run_i(run), .loop_i(loop),
        .fb_clk_i(g), .ref_clk_o(ref_clk), .ext_fb_o(ext_fb));
    pcsc_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .ref_clk_in_i(ref_clk),
        .ext_fb_in_i(ext_fb), .fb_route_i(route), .ref_passthru_i(pass),
        .ref_divider_i(4'h0), .fb_divider_i(6'h01),
        .vco_out_divider_i(3'h0), .fb_delay_dyn_i(fb_dyn),
        .out_delay_dyn_i(out_dyn), .fb_delay_fixed_i(fb_fix),
        .out_delay_fixed_i(out_fix), .fine_delay_sel_i(sel),
        .shifter_ratio_sel_i(ratio), .quad_shift_i(quad),
        .hold_ctrl_en_i(hold_en), .low_power_hold_i(hold),
        .synth_clk_global_o(g), .synth_clk_fabric_o(f),
        .synth_clk_global_port_a_o(ga), .synth_clk_fabric_port_a_o(fa),
        .lock_o(lock), .low_power_o(lp), .fb_delay_taps_o(fbt),
        .out_delay_taps_o(outt), .fb_delay_ps_o(fbps),
        .out_delay_ps_o(outps), .shifter_div_o(sdiv));

    // ----
    // Tasks
    // ----
    task automatic check(input string nm, input logic [11:0] s, e);
        #1;
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
        // Realign so the next stimulus lands on a rising edge
        @(posedge clk_i);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic rst();
        tick(1);
        nrst_i <= 1'b0;
        tick(2);
        check("lock in reset", 12'(lock), 12'h000);
        nrst_i <= 1'b1;
        tick(2);
        check("lock after reset", 12'(lock), 12'h000);
    endtask
    task automatic wait_lock();
        n = 0;
        while (lock !== 1'b1 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
    endtask
    // Cycles from a reference pin rise to the next output rise
    task automatic lag();
        @(posedge ref_clk);
        d = 0;
        while (g !== 1'b1 && d < 200) begin
            @(negedge clk_i);
            d++;
        end
    endtask
    // Counts output rises and disagreeing outputs over k cycles
    task automatic measure(input int k);
        logic pv;
        n = 0;
        d = 0;
        @(negedge clk_i);
        pv = g;
        repeat (k) begin
            @(negedge clk_i);
            if (g === 1'b1 && pv === 1'b0) n++;
            if ({f, ga, fa} !== {3{g}}) d++;
            pv = g;
        end
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Watchdog well beyond the expected run of about 7k cycles
    initial begin
        #400us;
        error_cnt++;
        results();
    end

    // ----
    // Tests
    // ----
    initial begin
        {nrst_i, run, loop, pass, ratio, fb_dyn, out_dyn} = 7'h00;
        {hold_en, hold, route, fb_fix, out_fix, sel} = 20'h00000;
        quad = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        // The four checks below use up the rest of the 12 reset cycles
        tick(8);
        check("lock", 12'(lock), 12'h000);
        check("fb taps", 12'(fbt), 12'h000);
        check("fb ps", fbps, 12'h096);
        check("divide", 12'(sdiv), 12'h004);
        nrst_i <= 1'b1;
        run <= 1'b1;
        fb_fix <= 4'hf;
        out_fix <= 4'h1;
        sel <= 8'h35;
        tick(2);
        check("fb taps fixed", 12'(fbt), 12'h00f);
        check("fb ps max", fbps, 12'h960);
        check("out ps fixed", outps, 12'h12c);
        fb_dyn <= 1'b1;
        out_dyn <= 1'b1;
        ratio <= 1'b1;
        tick(2);
        check("fb taps dyn", 12'(fbt), 12'h005);
        check("fb ps dyn", fbps, 12'h384);
        check("out taps dyn", 12'(outt), 12'h003);
        check("out ps dyn", outps, 12'h258);
        check("divide 7", 12'(sdiv), 12'h007);
        ratio <= 1'b0;
        pass <= 1'b1;
        tick(20);
        check("divide 4", 12'(sdiv), 12'h004);
        measure(400);
        check("passthru rises", 12'(n), 12'h004);
        pass <= 1'b0;
        for (int r = 1; r < 4; r++) begin
            route <= 2'(r);
            quad <= (r == 2);
            loop <= 1'b1;
            rst();
            wait_lock();
            check("lock on route", 12'(lock), 12'h001);
            measure(400);
            check("locked rises", 12'(n), 12'h008);
            check("outputs equal", 12'(d), 12'h000);
            // Quarter of the 50-cycle output period, rounded down
            lag();
            if (r == 1) base = d;
            if (r == 2) check("quarter lag", 12'(d - base), 12'h00c);
        end
        loop <= 1'b0;
        rst();
        tick(1500);
        check("no ext feedback", 12'(lock), 12'h000);
        route <= 2'h1;
        loop <= 1'b1;
        rst();
        wait_lock();
        hold_en <= 1'b1;
        hold <= 1'b1;
        tick(2);
        check("low power", 12'(lp), 12'h001);
        measure(400);
        check("frozen rises", 12'(n), 12'h000);
        check("lock on hold", 12'(lock), 12'h000);
        hold_en <= 1'b0;
        tick(2);
        check("hold disabled", 12'(lp), 12'h000);
        hold <= 1'b0;
        tick(2);
        results();
    end
endmodule
